// ---- hdl/hub_reset_sequencer.sv ----
`timescale 1ns/10ps
module hub_reset_sequencer #(
   parameter int unsigned RECOVER_CYC_P = hub_rst_pkg::RECOVER_CYC,
   parameter int unsigned CFG_TIMEOUT_P = hub_rst_pkg::CFG_TIMEOUT_CYC
) (
   // Clock and power-on reset
   input  wire logic                          i_clock,
   input  wire logic                          i_rst_n,
   // Link to the upstream host and configuration source
   hub_link_if.dev                            link,
   // Pins covered by the continuity test
   input  wire logic [hub_rst_pkg::NTEST-1:0] i_tested_pins,
   // Downstream port and analogue controls
   output logic      [hub_rst_pkg::NPORT-1:0] o_port_power_en,
   output logic                               o_osc_run,
   output logic                               o_pll_run,
   output logic                               o_tt_flush,
   // Status
   output logic                               o_operational,
   output logic                               o_configured,
   output logic                               o_suspended,
   output logic      [6:0]                    o_usb_addr
);
   import hub_rst_pkg::*;

   typedef struct packed {
      logic [1:0]       rst_sync;
      dev_pins_t        pin_s1;
      dev_pins_t        pin_s2;
      dev_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic [1:0]       mode;
      logic [1:0]       strap;
      logic [6:0]       addr;
      logic             configured;
      logic             suspended;
      logic [NPORT-1:0] ports;
      logic             tt_flush;
      logic             attach;
      logic             eeprom_rd;
      logic             ack;
      logic [1:0]       led;
      logic [1:0]       led_oe;
      logic             phy_en;
      logic             clk_run;
      logic             operational;
   } dev_reg_t;

   dev_reg_t  st_ff;
   dev_reg_t  nxt_st;
   dev_pins_t pins_raw;
   dev_pins_t pin;
   logic      hw_rst_n;

   // The pin acts on every flop at once; release is resynchronised below.
   assign hw_rst_n = i_rst_n & link.hw_reset_n;

   always_comb
   begin
      pins_raw.bus_reset        = link.bus_reset;
      pins_raw.ctrl_req         = link.ctrl_req;
      pins_raw.ctrl_op          = link.ctrl_op;
      pins_raw.ctrl_data        = link.ctrl_data;
      pins_raw.cfg_done         = link.cfg_done;
      pins_raw.suspend          = link.suspend;
      pins_raw.test_mode_pin    = link.test_mode_pin;
      pins_raw.cfg_sel          = link.cfg_sel;
      pins_raw.serial_cfg_clock = link.serial_cfg_clock;
      pins_raw.led_pin          = link.led_pin;
      pins_raw.tested           = i_tested_pins;
   end

   assign pin = st_ff.pin_s2;

   always_comb
   begin
      nxt_st          = st_ff;
      nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
      nxt_st.pin_s1   = pins_raw;
      nxt_st.pin_s2   = st_ff.pin_s1;
      nxt_st.tt_flush = 1'b0;
      unique case (st_ff.state)
         ST_RESET:
         begin
            if (st_ff.rst_sync[1])
            begin
               nxt_st.clk_run = 1'b1;
               nxt_st.mode    = pin.cfg_sel;
               nxt_st.strap   = pin.led_pin;
               nxt_st.cnt     = '0;
               if (pin.test_mode_pin && pin.cfg_sel[1] &&
                   !pin.serial_cfg_clock)
                  nxt_st.state = ST_TEST;
               else
                  nxt_st.state = ST_RECOVER;
            end
         end
         ST_TEST:
         begin
            // Only a new hardware reset leaves the continuity test.
            nxt_st.led_oe[LED_GREEN] = 1'b1;
            nxt_st.led[LED_GREEN]    = ~^pin.tested;
         end
         ST_RECOVER:
         begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            if (st_ff.cnt == CNT_W'(RECOVER_CYC_P - 1))
            begin
               nxt_st.operational = 1'b1;
               nxt_st.cnt         = '0;
               if (st_ff.mode == CFG_STRAP)
                  nxt_st.state = ST_APPLY;
               else
               begin
                  nxt_st.state     = ST_CFG;
                  nxt_st.eeprom_rd = (st_ff.mode != CFG_SMBUS);
               end
            end
         end
         ST_CFG:
         begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            // A missing EEPROM must not stall attach; defaults are kept.
            if (pin.cfg_done || (st_ff.mode != CFG_SMBUS &&
                st_ff.cnt == CNT_W'(CFG_TIMEOUT_P - 1)))
            begin
               nxt_st.eeprom_rd = 1'b0;
               nxt_st.cnt       = '0;
               nxt_st.state     = ST_APPLY;
            end
         end
         ST_APPLY:
         begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
            if (st_ff.cnt == CNT_W'(APPLY_CYC - 1))
            begin
               nxt_st.attach = 1'b1;
               nxt_st.phy_en = 1'b1;
               nxt_st.led_oe = 2'h3;
               nxt_st.led    = st_ff.strap;
               nxt_st.cnt    = '0;
               nxt_st.state  = ST_RUN;
            end
         end
         ST_RUN:
         begin
            nxt_st.suspended = pin.suspend;
            // The green LED shows port power; a high strap means active-low drive.
            nxt_st.led[LED_GREEN] = (|st_ff.ports) ^ st_ff.strap[LED_GREEN];
            nxt_st.led[LED_AMBER] = st_ff.strap[LED_AMBER];
            if (pin.bus_reset)
            begin
               // Also drops power to every downstream port and pulses the TT flush.
               nxt_st.addr       = ADDR_RST;
               nxt_st.configured = 1'b0;
               nxt_st.ports      = '0;
               nxt_st.tt_flush   = 1'b1;
               nxt_st.suspended  = 1'b0;
               nxt_st.ack        = 1'b0;
               nxt_st.cnt        = '0;
            end
            else if (pin.ctrl_req && !st_ff.ack)
            begin
               nxt_st.cnt = st_ff.cnt + 1'b1;
               if (st_ff.cnt == CNT_W'(CTRL_LAT_CYC - 1))
               begin
                  nxt_st.ack = 1'b1;
                  nxt_st.cnt = '0;
                  unique case (pin.ctrl_op)
                     OP_NONE:
                        nxt_st.ack = 1'b1;
                     OP_SET_ADDR:
                        nxt_st.addr = pin.ctrl_data;
                     OP_SET_CONFIG:
                     begin
                        nxt_st.configured = pin.ctrl_data[0];
                        if (!pin.ctrl_data[0])
                           nxt_st.ports = '0;
                     end
                     OP_PORT_POWER:
                        nxt_st.ports = st_ff.configured ?
                                       pin.ctrl_data[NPORT-1:0] : '0;
                  endcase
               end
            end
            else if (!pin.ctrl_req)
            begin
               nxt_st.ack = 1'b0;
               nxt_st.cnt = '0;
            end
         end
      endcase
   end

   // Every field clears while the pin is low, so nothing survives a reset.
   always_ff @(posedge i_clock or negedge hw_rst_n)
   begin
      if (!hw_rst_n)
      begin
         st_ff       <= '0;
         st_ff.state <= ST_RESET;
         st_ff.addr  <= ADDR_RST;
      end
      else
         st_ff <= nxt_st;
   end

   assign o_port_power_en = st_ff.ports;
   assign o_osc_run       = st_ff.clk_run;
   assign o_pll_run       = st_ff.clk_run;
   assign o_tt_flush      = st_ff.tt_flush;
   assign o_operational   = st_ff.operational;
   assign o_configured    = st_ff.configured;
   assign o_suspended     = st_ff.suspended;
   assign o_usb_addr      = st_ff.addr;
   assign link.attach     = st_ff.attach;
   assign link.eeprom_rd  = st_ff.eeprom_rd;
   assign link.ctrl_ack   = st_ff.ack;
   assign link.phy_en     = st_ff.phy_en;
   assign link.led_o      = st_ff.led;
   assign link.led_oe     = st_ff.led_oe;

endmodule : hub_reset_sequencer

// ---- hdl/hub_upstream_host.sv ----
`timescale 1ns/10ps
module hub_upstream_host #(
   parameter int unsigned HOST_WAIT_P = hub_rst_pkg::HOST_WAIT_CYC
) (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // Link to the hub
   hub_link_if.host        link,
   // Reset and configuration controls
   input  wire logic       i_hw_reset_req,
   input  wire logic       i_cfg_done,
   input  wire logic       i_suspend,
   input  wire logic       i_test_mode,
   input  wire logic [1:0] i_cfg_sel,
   input  wire logic       i_serial_cfg_clock,
   input  wire logic [1:0] i_led_strap,
   // Control request port
   input  wire logic       i_ctrl_start,
   input  wire logic [1:0] i_ctrl_op,
   input  wire logic [6:0] i_ctrl_data,
   output logic            o_ctrl_done,
   // Status
   output logic            o_attached,
   output logic            o_ready
);
   import hub_rst_pkg::*;

   typedef struct packed {
      logic [1:0]       s1;
      logic [1:0]       s2;
      host_state_t      state;
      logic [CNT_W-1:0] cnt;
      logic             hw_reset_n;
      logic             bus_reset;
      logic             req;
      logic             busy;
      logic             done;
      logic [1:0]       op;
      logic [6:0]       data;
      logic             cfg_done;
      logic             suspend;
      logic             test_mode;
      logic [1:0]       cfg_sel;
      logic             sclk;
      logic [1:0]       strap;
   } host_reg_t;

   host_reg_t st_ff;
   host_reg_t nxt_st;
   logic      attach_s;
   logic      ack_s;

   assign attach_s = st_ff.s2[1];
   assign ack_s    = st_ff.s2[0];

   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.s1        = {link.attach, link.ctrl_ack};
      nxt_st.s2        = st_ff.s1;
      nxt_st.done      = 1'b0;
      nxt_st.cfg_done  = i_cfg_done;
      nxt_st.suspend   = i_suspend;
      nxt_st.test_mode = i_test_mode;
      nxt_st.cfg_sel   = i_cfg_sel;
      nxt_st.sclk      = i_serial_cfg_clock;
      nxt_st.strap     = i_led_strap;
      nxt_st.cnt       = st_ff.cnt + 1'b1;
      unique case (st_ff.state)
         H_RESET:
         begin
            nxt_st.hw_reset_n = 1'b0;
            if (st_ff.cnt == CNT_W'(HWRST_CYC - 1))
            begin
               nxt_st.hw_reset_n = 1'b1;
               nxt_st.state      = H_WAIT_ATTACH;
            end
         end
         H_WAIT_ATTACH:
         begin
            nxt_st.cnt = '0;
            if (attach_s)
               nxt_st.state = H_ATTACHED;
         end
         H_ATTACHED:
         begin
            if (st_ff.cnt == CNT_W'(HOST_WAIT_P - 1))
            begin
               nxt_st.bus_reset = 1'b1;
               nxt_st.cnt       = '0;
               nxt_st.state     = H_BUSRST;
            end
         end
         H_BUSRST:
         begin
            if (st_ff.cnt == CNT_W'(BUS_RST_CYC - 1))
            begin
               nxt_st.bus_reset = 1'b0;
               nxt_st.state     = H_READY;
            end
         end
         H_READY:
         begin
            nxt_st.cnt = '0;
            // Four-phase handshake: drop the request on ack, finish on
            // ack release, so each request is seen exactly once.
            if (i_ctrl_start && !st_ff.busy && !ack_s)
            begin
               nxt_st.op   = i_ctrl_op;
               nxt_st.data = i_ctrl_data;
               nxt_st.req  = 1'b1;
               nxt_st.busy = 1'b1;
            end
            else if (st_ff.req && ack_s)
               nxt_st.req = 1'b0;
            else if (st_ff.busy && !st_ff.req && !ack_s)
            begin
               nxt_st.busy = 1'b0;
               nxt_st.done = 1'b1;
            end
         end
      endcase
      if (i_hw_reset_req)
      begin
         nxt_st.state      = H_RESET;
         nxt_st.cnt        = '0;
         nxt_st.hw_reset_n = 1'b0;
         nxt_st.bus_reset  = 1'b0;
         nxt_st.req        = 1'b0;
         nxt_st.busy       = 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_ff       <= '0;
         st_ff.state <= H_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   assign link.hw_reset_n       = st_ff.hw_reset_n;
   assign link.bus_reset        = st_ff.bus_reset;
   assign link.ctrl_req         = st_ff.req;
   assign link.ctrl_op          = st_ff.op;
   assign link.ctrl_data        = st_ff.data;
   assign link.cfg_done         = st_ff.cfg_done;
   assign link.suspend          = st_ff.suspend;
   assign link.test_mode_pin    = st_ff.test_mode;
   assign link.cfg_sel          = st_ff.cfg_sel;
   assign link.serial_cfg_clock = st_ff.sclk;
   assign link.led_strap        = st_ff.strap;
   assign o_ctrl_done           = st_ff.done;
   assign o_attached            = attach_s;
   assign o_ready               = (st_ff.state == H_READY) && !st_ff.busy;

endmodule : hub_upstream_host

// ---- shared/hub_link_if.sv ----
`timescale 1ns/10ps
interface hub_link_if;
   import hub_rst_pkg::*;

   // Host end to device.
   logic       hw_reset_n;
   logic       bus_reset;
   logic       ctrl_req;
   logic [1:0] ctrl_op;
   logic [6:0] ctrl_data;
   logic       cfg_done;
   logic       suspend;
   logic       test_mode_pin;
   logic [1:0] cfg_sel;
   logic       serial_cfg_clock;
   logic [1:0] led_strap;
   // Device end to host.
   logic       attach;
   logic       eeprom_rd;
   logic       ctrl_ack;
   logic       phy_en;
   logic [1:0] led_o;
   logic [1:0] led_oe;
   // Resolved LED pin levels: driven by the device, else the strap.
   logic [1:0] led_pin;

   assign led_pin = (led_o & led_oe) | (led_strap & ~led_oe);

   modport dev (
      input  hw_reset_n, bus_reset, ctrl_req, ctrl_op, ctrl_data,
      input  cfg_done, suspend, test_mode_pin, cfg_sel, serial_cfg_clock,
      input  led_pin,
      output attach, eeprom_rd, ctrl_ack, phy_en, led_o, led_oe
   );

   modport host (
      output hw_reset_n, bus_reset, ctrl_req, ctrl_op, ctrl_data,
      output cfg_done, suspend, test_mode_pin, cfg_sel, serial_cfg_clock,
      output led_strap,
      input  attach, eeprom_rd, ctrl_ack, phy_en, led_pin
   );

endinterface : hub_link_if

// ---- shared/hub_rst_pkg.sv ----
package hub_rst_pkg;

   // Clock rate and the timing figures, each followed by its cycle count.
   localparam int unsigned CLK_MHZ           = 40;
   localparam int unsigned T_HWRST_MIN_NS    = 1000;
   localparam int unsigned HWRST_CYC         =
      (T_HWRST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned T_INACTIVE_MAX_NS = 1500;
   localparam int unsigned INACTIVE_CYC      =
      (T_INACTIVE_MAX_NS * CLK_MHZ) / 1000;
   localparam int unsigned T_RECOVER_US      = 500;
   localparam int unsigned RECOVER_CYC       = T_RECOVER_US * CLK_MHZ;
   localparam int unsigned T_CFG_MAX_NS      = 99_500_000;
   localparam int unsigned CFG_TIMEOUT_CYC   = T_CFG_MAX_NS / 1000 * CLK_MHZ;
   localparam int unsigned T_ATTACH_MAX_US   = 100_000;
   localparam int unsigned ATTACH_MAX_CYC    = T_ATTACH_MAX_US * CLK_MHZ;
   localparam int unsigned T_HOST_WAIT_US    = 100_000;
   localparam int unsigned HOST_WAIT_CYC     = T_HOST_WAIT_US * CLK_MHZ;
   localparam int unsigned T_REQ_MAX_US      = 5000;
   localparam int unsigned REQ_MAX_CYC       = T_REQ_MAX_US * CLK_MHZ;

   // Fixed internal latencies, all far inside the bounds above, and the counter width.
   localparam int unsigned APPLY_CYC         = 16;
   localparam int unsigned CTRL_LAT_CYC      = 8;
   localparam int unsigned BUS_RST_CYC       = 400;
   localparam int unsigned CNT_W             = 22;

   // Widths and reset values.
   localparam int unsigned NPORT             = 7;
   localparam int unsigned NTEST             = 8;
   localparam logic [6:0]  ADDR_RST          = 7'h00;

   // Configuration source selected by the config_select pins.
   localparam logic [1:0]  CFG_STRAP         = 2'h0;
   localparam logic [1:0]  CFG_EEPROM        = 2'h1;
   localparam logic [1:0]  CFG_SMBUS         = 2'h2;

   // Control request operations.
   localparam logic [1:0]  OP_NONE           = 2'h0;
   localparam logic [1:0]  OP_SET_ADDR       = 2'h1;
   localparam logic [1:0]  OP_SET_CONFIG     = 2'h2;
   localparam logic [1:0]  OP_PORT_POWER     = 2'h3;

   // LED lane numbers.
   localparam int unsigned LED_AMBER         = 0;
   localparam int unsigned LED_GREEN         = 1;

   typedef enum logic [2:0] {
      ST_RESET, ST_TEST, ST_RECOVER, ST_CFG, ST_APPLY, ST_RUN
   } dev_state_t;

   typedef enum logic [2:0] {
      H_RESET, H_WAIT_ATTACH, H_ATTACHED, H_BUSRST, H_READY
   } host_state_t;

   // Pins that reach the device from outside its clock domain.
   typedef struct packed {
      logic             bus_reset;
      logic             ctrl_req;
      logic [1:0]       ctrl_op;
      logic [6:0]       ctrl_data;
      logic             cfg_done;
      logic             suspend;
      logic             test_mode_pin;
      logic [1:0]       cfg_sel;
      logic             serial_cfg_clock;
      logic [1:0]       led_pin;
      logic [NTEST-1:0] tested;
   } dev_pins_t;

endpackage : hub_rst_pkg

// ---- sim/hub_reset_sequencer_monitor.sv ----
`timescale 1ns/10ps
module hub_reset_sequencer_monitor #(
   parameter int unsigned RECOVER_CYC_P = 50,
   parameter int unsigned CFG_TIMEOUT_P = 200,
   parameter int unsigned HOST_WAIT_P   = 100
) (
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_rst_n,
   // Link signals
   input wire logic       i_hw_reset_n,
   input wire logic       i_bus_reset,
   input wire logic       i_ctrl_req,
   input wire logic       i_ctrl_ack,
   input wire logic [1:0] i_cfg_sel,
   input wire logic       i_attach,
   input wire logic       i_eeprom_rd,
   input wire logic       i_phy_en,
   input wire logic [1:0] i_led_oe
);
   import hub_rst_pkg::*;

   // Cycles since release, in the EEPROM read, since attach and in reset.
   logic [15:0] rel_ff;
   logic [15:0] rd_ff;
   logic [15:0] att_ff;
   logic [15:0] low_ff;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rel_ff <= 16'h0000;
         rd_ff  <= 16'h0000;
         att_ff <= 16'h0000;
         low_ff <= 16'h0000;
      end
      else
      begin
         rel_ff <= i_hw_reset_n ? rel_ff + 16'h0001 : 16'h0000;
         rd_ff  <= i_eeprom_rd ? rd_ff + 16'h0001 : 16'h0000;
         att_ff <= i_attach ? att_ff + 16'h0001 : 16'h0000;
         low_ff <= i_hw_reset_n ? 16'h0000 : low_ff + 16'h0001;
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   a_reset_width: assert property (
      $rose(i_hw_reset_n) |-> low_ff >= HWRST_CYC)
      else $error("hardware reset pulse too short");
   a_reset_phy_off: assert property (
      !i_hw_reset_n |-> !i_phy_en && !i_attach)
      else $error("transceiver or attach active in reset");
   a_reset_leds_off: assert property (
      !i_hw_reset_n |-> i_led_oe == 2'h0)
      else $error("LED driven in reset");
   a_reset_abort: assert property (
      !i_hw_reset_n |-> !i_ctrl_ack && !i_eeprom_rd)
      else $error("transaction alive in reset");
   a_eeprom_start: assert property (
      disable iff (!i_rst_n || !i_hw_reset_n)
      $rose(i_eeprom_rd) |->
      rel_ff >= RECOVER_CYC_P && rel_ff <= RECOVER_CYC_P + 6)
      else $error("configuration read started at wrong time");
   a_eeprom_bound: assert property (
      disable iff (!i_rst_n || !i_hw_reset_n)
      rd_ff <= CFG_TIMEOUT_P + 4)
      else $error("configuration read too long");
   a_attach_after_cfg: assert property (
      disable iff (!i_rst_n || !i_hw_reset_n)
      $fell(i_eeprom_rd) |-> ##[14:20] i_attach)
      else $error("attach late after configuration");
   a_strap_attach: assert property (
      disable iff (!i_rst_n || !i_hw_reset_n)
      $rose(i_attach) && i_cfg_sel == CFG_STRAP |->
      rel_ff >= RECOVER_CYC_P + 14 && rel_ff <= RECOVER_CYC_P + 24)
      else $error("strap attach at wrong time");
   a_host_wait: assert property (
      $rose(i_bus_reset) |-> att_ff >= HOST_WAIT_P)
      else $error("bus reset too soon after attach");
   a_ctrl_answer: assert property (
      $rose(i_ctrl_req) |-> ##[8:13] i_ctrl_ack)
      else $error("request not answered in time");
   a_ack_release: assert property (
      $fell(i_ctrl_req) |-> ##[1:6] !i_ctrl_ack)
      else $error("acknowledge not released");

   c_attach: cover property ($rose(i_attach));
   c_bus_reset: cover property ($rose(i_bus_reset));
   c_ctrl_ack: cover property ($rose(i_ctrl_ack));
   c_test_led: cover property (i_hw_reset_n && i_led_oe == 2'h2);
endmodule : hub_reset_sequencer_monitor

// ---- sim/hub_reset_sequencer_tb.sv ----
`timescale 1ns/10ps
module hub_reset_sequencer_tb;
   import hub_rst_pkg::*;

   localparam int unsigned REC = 50;
   localparam int unsigned CTO = 200;
   localparam int unsigned HWT = 100;
   // All tests take about 3500 cycles.
   localparam int unsigned LIMIT = 20000;

   logic       i_clock  = 1'b0;
   logic       i_rst_n  = 1'b0;
   logic       hw_req   = 1'b0;
   logic       cfg_done = 1'b0;
   logic       susp     = 1'b0;
   logic       tmode    = 1'b0;
   logic [1:0] sel      = 2'h0;
   logic       sclk     = 1'b0;
   logic [1:0] strap    = 2'h0;
   logic       start    = 1'b0;
   logic [1:0] op       = 2'h0;
   logic [6:0] data     = 7'h00;
   logic [7:0] tested   = 8'h00;
   logic       done, attached, ready, osc, pll, flush, oper, cfgd, suspd;
   logic [6:0] ports;
   logic [6:0] addr;
   int         n_errors  = 0;
   int         cmp_count = 0;
   int         n_flush   = 0;
   int         cyc       = 0;

   hub_link_if hub_link_if_inst ();

   hub_reset_sequencer #(.RECOVER_CYC_P(REC), .CFG_TIMEOUT_P(CTO))
   hub_reset_sequencer_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .link(hub_link_if_inst), .i_tested_pins(tested),
      .o_port_power_en(ports), .o_osc_run(osc), .o_pll_run(pll),
      .o_tt_flush(flush), .o_operational(oper), .o_configured(cfgd),
      .o_suspended(suspd), .o_usb_addr(addr));

   hub_upstream_host #(.HOST_WAIT_P(HWT))
   hub_upstream_host_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .link(hub_link_if_inst), .i_hw_reset_req(hw_req),
      .i_cfg_done(cfg_done), .i_suspend(susp), .i_test_mode(tmode),
      .i_cfg_sel(sel), .i_serial_cfg_clock(sclk), .i_led_strap(strap),
      .i_ctrl_start(start), .i_ctrl_op(op), .i_ctrl_data(data),
      .o_ctrl_done(done), .o_attached(attached), .o_ready(ready));

   hub_reset_sequencer_monitor #(.RECOVER_CYC_P(REC),
      .CFG_TIMEOUT_P(CTO), .HOST_WAIT_P(HWT))
   hub_reset_sequencer_monitor_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_hw_reset_n(hub_link_if_inst.hw_reset_n),
      .i_bus_reset(hub_link_if_inst.bus_reset),
      .i_ctrl_req(hub_link_if_inst.ctrl_req),
      .i_ctrl_ack(hub_link_if_inst.ctrl_ack),
      .i_cfg_sel(hub_link_if_inst.cfg_sel),
      .i_attach(hub_link_if_inst.attach),
      .i_eeprom_rd(hub_link_if_inst.eeprom_rd),
      .i_phy_en(hub_link_if_inst.phy_en),
      .i_led_oe(hub_link_if_inst.led_oe));

   always #12.5 i_clock = ~i_clock;

   task conclude;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude

   always @(posedge i_clock)
   begin
      cyc++;
      if (flush === 1'b1)
         n_flush++;
      if (cyc == LIMIT)
      begin
         n_errors++;
         conclude();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Outputs are sampled just after the edge, before its updates land.
   task wait_ready;
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 3000)
      begin
         @(posedge i_clock);
         n++;
      end
      chk({7'h0, ready}, 8'h01);
   endtask : wait_ready

   task boot(input logic [1:0] s, input logic t, input logic [1:0] st);
      sel      <= s;
      tmode    <= t;
      strap    <= st;
      cfg_done <= 1'b0;
      hw_req   <= 1'b1;
      repeat (20) @(posedge i_clock);
      chk({1'b0, ports}, 8'h00);
      chk({6'h0, osc, pll}, 8'h00);
      chk({6'h0, hub_link_if_inst.led_oe}, 8'h00);
      chk({7'h0, hub_link_if_inst.phy_en}, 8'h00);
      chk({1'b0, addr}, 8'h00);
      hw_req <= 1'b0;
   endtask : boot

   task ctrl(input logic [1:0] o, input logic [6:0] d);
      int n;
      wait_ready();
      op    <= o;
      data  <= d;
      start <= 1'b1;
      @(posedge i_clock);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 100)
      begin
         @(posedge i_clock);
         n++;
      end
      chk({7'h0, done}, 8'h01);
      @(posedge i_clock);
   endtask : ctrl

   initial
   begin
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      boot(CFG_STRAP, 1'b0, 2'b01);
      // A suspended hub must be woken by the bus reset.
      susp <= 1'b1;
      while (hub_link_if_inst.bus_reset !== 1'b1)
         @(posedge i_clock);
      chk({6'h0, suspd, attached}, 8'h03);
      repeat (10) @(posedge i_clock);
      chk({6'h0, suspd, attached}, 8'h01);
      susp <= 1'b0;
      wait_ready();
      chk({6'h0, oper, cfgd}, 8'h02);
      chk({7'h0, (n_flush != 0)}, 8'h01);
      chk({6'h0, hub_link_if_inst.led_pin}, 8'h01);
      ctrl(OP_PORT_POWER, 7'h7F);
      chk({1'b0, ports}, 8'h00);
      ctrl(OP_SET_ADDR, 7'h2A);
      ctrl(OP_NONE, 7'h15);
      chk({1'b0, addr}, 8'h2A);
      ctrl(OP_SET_CONFIG, 7'h01);
      ctrl(OP_PORT_POWER, 7'h55);
      chk({1'b0, ports}, 8'h55);
      chk({6'h0, cfgd, hub_link_if_inst.led_pin[1]}, 8'h03);
      ctrl(OP_SET_CONFIG, 7'h00);
      chk({cfgd, ports}, 8'h00);
      for (int m = 1; m < 4; m++)
      begin
         boot(2'(m), 1'b0, 2'b00);
         repeat (120) @(posedge i_clock);
         chk({6'h0, hub_link_if_inst.attach, hub_link_if_inst.eeprom_rd},
            (m == 2) ? 8'h00 : 8'h01);
         if (m == 2)
         begin
            // Loading from the slave port has no time limit of its own.
            repeat (400) @(posedge i_clock);
            chk({7'h0, hub_link_if_inst.attach}, 8'h00);
         end
         if (m != 3)
            cfg_done <= 1'b1;
         wait_ready();
         chk({1'b0, addr}, 8'h00);
         chk({1'b0, ports}, 8'h00);
      end
      boot(2'b11, 1'b1, 2'b00);
      repeat (150) @(posedge i_clock);
      for (int k = 0; k < 8; k++)
      begin
         tested <= tested ^ (8'h01 << k);
         repeat (5) @(posedge i_clock);
         chk({6'h0, hub_link_if_inst.led_oe[1], hub_link_if_inst.led_pin[1]},
            {6'h0, 1'b1, ~^tested});
      end
      conclude();
   end
endmodule : hub_reset_sequencer_tb
